//--- isc_pkg.sv
// Constants shared by the idle/standby command unit and its helpers.
// Assumes a 25 MHz system clock and a 32-bit classic Wishbone slave.
package isc_pkg;

    // ************************************************
    // Command opcodes and feature options
    // ************************************************
    localparam logic [7:0] OPC_IDLE      = 8'he3;
    localparam logic [7:0] OPC_IDLE_ALT  = 8'h97;
    localparam logic [7:0] OPC_IDLE_IMM  = 8'he1;
    localparam logic [7:0] OPC_INIT_GEOM = 8'h91;
    localparam logic [7:0] FEAT_REVERT   = 8'hcc;
    localparam logic [7:0] FEAT_KEEP     = 8'h66;

    // ************************************************
    // Register byte offsets
    // ************************************************
    localparam logic [7:0] ADR_CMD     = 8'h00;
    localparam logic [7:0] ADR_STATUS  = 8'h04;
    localparam logic [7:0] ADR_ACCESS  = 8'h08;
    localparam logic [7:0] ADR_GEOM    = 8'h0c;
    localparam logic [7:0] ADR_FEAT    = 8'h10;
    localparam logic [7:0] ADR_SRST    = 8'h14;
    localparam logic [7:0] ADR_ID_WR   = 8'h18;
    localparam logic [7:0] ADR_ID_LAST = 8'h1c;
    localparam logic [7:0] ADR_IRQ_STS = 8'h20;
    localparam logic [7:0] ADR_IRQ_CLR = 8'h24;
    localparam logic [7:0] ADR_IRQ_EN  = 8'h28;

    // ************************************************
    // Field positions
    // ************************************************
    localparam int STS_ERR_BIT   = 0;
    localparam int STS_SENSE_BIT = 1;
    localparam int STS_FAULT_BIT = 5;
    localparam int STS_RDY_BIT   = 6;
    localparam int ERR_ABORT_BIT = 2;
    localparam int IRQ_DONE_BIT  = 0;
    localparam int IRQ_ABORT_BIT = 1;
    localparam int IRQ_SLEEP_BIT = 2;
    localparam int IRQ_W         = 3;

    // ************************************************
    // Standby count encoding
    // ************************************************
    localparam logic [7:0]  CNT_OFF       = 8'h00;
    localparam logic [7:0]  CNT_LIN_MAX   = 8'hf0;
    localparam logic [7:0]  CNT_HALFH_MAX = 8'hfb;
    localparam logic [7:0]  CNT_21M       = 8'hfc;
    localparam logic [7:0]  CNT_VENDOR    = 8'hfd;
    localparam logic [7:0]  CNT_ABORT     = 8'hfe;
    localparam int          SEC_W         = 17;
    localparam logic [16:0] SEC_PER_UNIT  = 17'h00005;
    localparam logic [16:0] SEC_HALF_HOUR = 17'h00708;
    localparam logic [16:0] SEC_21M       = 17'h004ec;
    localparam logic [16:0] SEC_21M15     = 17'h004fb;
    localparam logic [16:0] SEC_VENDOR    = 17'h08ca0;

    // ************************************************
    // Timing
    // ************************************************
    localparam int CLK_HZ      = 25000000;
    localparam int TICK_SEC    = 1;
    localparam int TICK_CYCLES = TICK_SEC * CLK_HZ;

    // ************************************************
    // Identify data and reset values
    // ************************************************
    localparam logic [7:0] ID_SIG       = 8'ha5;
    localparam logic [7:0] ID_W_HEADS   = 8'h37;
    localparam logic [7:0] ID_W_SPT     = 8'h38;
    localparam logic [7:0] ID_W_LAST    = 8'hff;
    localparam logic [7:0] SPT_RST      = 8'h3f;
    localparam logic [3:0] HEADS_RST    = 4'hf;

    // Power states
    typedef enum logic [1:0] {PWR_ACTIVE, PWR_IDLE, PWR_STANDBY} isc_pwr_t;

endpackage

//--- isc_interval_dec.sv
// Decoder from the standby count byte to an interval in seconds.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module isc_interval_dec
    import isc_pkg::*;
(
    input  wire logic [7:0]       count_i,
    output logic      [SEC_W-1:0] secs_o,
    output logic                  enable_o,
    output logic                  abort_o
);
    // ************************************************
    // Decode
    // ************************************************
    always_comb begin
        enable_o = (count_i != CNT_OFF);
        abort_o  = 1'b0;
        if (count_i == CNT_OFF) begin
            secs_o = '0;
        end else if (count_i <= CNT_LIN_MAX) begin
            // Value times five seconds
            secs_o = SEC_W'(count_i) * SEC_PER_UNIT;
        end else if (count_i <= CNT_HALFH_MAX) begin
            // Half hours above the linear range
            secs_o = SEC_W'(count_i - CNT_LIN_MAX) * SEC_HALF_HOUR;
        end else if (count_i == CNT_21M) begin
            secs_o = SEC_21M;
        end else if (count_i == CNT_VENDOR) begin
            // Vendor window, a fixed point inside it
            secs_o = SEC_VENDOR;
        end else if (count_i == CNT_ABORT) begin
            secs_o   = '0;
            enable_o = 1'b0;
            abort_o  = 1'b1;
        end else begin
            secs_o = SEC_21M15;
        end
    end
endmodule // isc_interval_dec

//--- isc_id_sum.sv
// Builds the final identify word from the stream of words 0..254.
// Assumes software writes the words in order after a clear.
`timescale 1ns/1ps
module isc_id_sum
    import isc_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        clr_i,
    input  wire logic        wr_i,
    input  wire logic [15:0] word_i,
    input  wire logic [7:0]  spt_i,
    input  wire logic [3:0]  heads_i,
    output logic      [15:0] last_o,
    output logic      [7:0]  idx_o
);
    logic [7:0]  idx_q;   // Next word index
    logic [7:0]  sum_q;   // Running byte sum
    logic [15:0] word_s;  // Word after geometry substitution

    // Current geometry replaces the stream's copy
    always_comb begin
        if (idx_q == ID_W_HEADS) begin
            word_s = {12'h000, heads_i} + 16'h0001;
        end else if (idx_q == ID_W_SPT) begin
            word_s = {8'h00, spt_i};
        end else begin
            word_s = word_i;
        end
    end

    // ************************************************
    // Accumulate; the last word is never summed
    // ************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i || clr_i) begin
            idx_q <= '0;
            sum_q <= '0;
        end else if (wr_i && idx_q != ID_W_LAST) begin
            idx_q <= idx_q + 8'h01;
            sum_q <= sum_q + word_s[7:0] + word_s[15:8];
        end
    end

    // Signature byte is byte 510 and joins the sum
    assign last_o = {8'(8'h00 - sum_q - ID_SIG), ID_SIG}; // RL18
    assign idx_o  = idx_q;
endmodule // isc_id_sum

//--- isc_cmd_unit.sv
// Idle / standby command unit with geometry store and identify checksum.
// Assumes a classic Wishbone master on clk_i and an async spindle pin.
//
// Summary of operation
// RL1: Idle opcodes enter idle, load standby period
// RL2: Loaded standby timer then counts down
// RL3: Spin-up requested only when spindle not at speed
// RL4: Zero period disables power-down, else enabled
// RL5: 1-240 times five; 241-251 half hours
// RL6: 252 21m, 253 vendor, 254 abort, 255
// RL7: Expiry without access enters standby
// RL8: Host access reloads full interval
// RL9: Idle immediate enters idle, same spin-up
// RL10: Idle immediate keeps period and enable
// RL11: Errors set abort, error status bits
// RL12: Geometry command stores sectors and heads
// RL13: Stored geometry shown in identify words
// RL14: Geometry kept except reverting soft reset
// RL15: Zero sectors per track means zero
// RL16: Host keeps heads value within 0..15
// RL17: Host keeps cylinder count within limit
// RL18: Last identify word holds signature, checksum
// RL19: Timer advanced by prescaled one-second tick
`timescale 1ns/1ps
module isc_cmd_unit
    import isc_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES  // Cycles per timer tick
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    input  wire logic        we_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    output logic             ack_o,
    input  wire logic        spin_at_speed_i,
    output logic             spin_up_req_o,
    output logic      [1:0]  pwr_state_o,
    output logic             irq_o
);
    // ************************************************
    // Declarations
    // ************************************************
    logic             ack_q;        // Bus answer
    logic [31:0]      rdat_q;       // Read data
    logic [31:0]      wdat;         // Lane-masked write data
    logic             req;          // New bus request
    logic             wr_stb;       // Write accepted
    logic             cmd_go;       // Command written
    logic [7:0]       opc;          // Command opcode
    logic [7:0]       cnt;          // Count field
    logic             is_idle;      // Timer-loading idle
    logic             is_imm;       // Idle immediate
    logic             is_geom;      // Geometry command
    logic             cmd_abort;    // Command rejected
    logic             host_acc;     // Host touched drive
    logic [1:0]       spd_sync_q;   // Spindle pin sync
    logic             at_speed;     // Synced spindle level
    isc_pwr_t         pwr_q;        // Power state
    logic             spin_req_q;   // Spin-up request
    logic [SEC_W-1:0] period_q;     // Programmed interval
    logic             apd_en_q;     // Auto power-down on
    logic [SEC_W-1:0] sec_q;        // Seconds remaining
    logic [31:0]      pre_q;        // Tick prescaler
    logic             tick;         // One-second tick
    logic             expire;       // Timer ran out
    logic [SEC_W-1:0] dec_secs;     // Decoded interval
    logic             dec_en;       // Decoded enable
    logic             dec_abort;    // Decoded abort code
    logic [7:0]       ata_sts_q;    // Status byte
    logic [7:0]       ata_err_q;    // Error byte
    logic [7:0]       spt_q;        // Sectors per track
    logic [3:0]       heads_q;      // Heads minus one
    logic [7:0]       feat_q;       // Reset revert option
    logic [15:0]      id_last;      // Final identify word
    logic [7:0]       id_idx;       // Identify word index
    logic [IRQ_W-1:0] irq_sts_q;    // Sticky events
    logic [IRQ_W-1:0] irq_en_q;     // Event enables
    logic [IRQ_W-1:0] irq_set;      // Events this cycle
    logic             irq_q;        // Interrupt level

    // ************************************************
    // Bus decode
    // ************************************************
    // Byte lanes not selected write as zero
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            wdat[b*8 +: 8] = sel_i[b] ? dat_i[b*8 +: 8] : 8'h00;
        end
    end

    // One request per ack; the repeat cycle is ignored
    assign req    = cyc_i && stb_i && !ack_q;
    assign wr_stb = req && we_i;
    assign cmd_go = wr_stb && (adr_i == ADR_CMD);
    assign opc    = wdat[7:0];
    assign cnt    = wdat[15:8];

    assign is_idle = cmd_go && (opc == OPC_IDLE || opc == OPC_IDLE_ALT);
    assign is_imm  = cmd_go && (opc == OPC_IDLE_IMM);
    assign is_geom = cmd_go && (opc == OPC_INIT_GEOM);
    // Unknown opcodes are refused as well
    assign cmd_abort = (is_idle && dec_abort)
                     || (cmd_go && !is_idle && !is_imm && !is_geom); // RL6
    // Any command or access write counts as host access
    assign host_acc = cmd_go || (wr_stb && adr_i == ADR_ACCESS);

    // ************************************************
    // Wishbone answer, one wait-free cycle
    // ************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req;
        end
    end

    // Read mux; unmapped and write-only offsets read zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdat_q <= '0;
        end else if (req && !we_i) begin
            case (adr_i)
                ADR_STATUS:  rdat_q <= {12'h000, apd_en_q, 1'b0, pwr_q,
                                        ata_err_q, ata_sts_q};
                ADR_GEOM:    rdat_q <= {20'h00000, heads_q, spt_q};
                ADR_FEAT:    rdat_q <= {24'h000000, feat_q};
                ADR_ID_WR:   rdat_q <= {24'h000000, id_idx};
                ADR_ID_LAST: rdat_q <= {16'h0000, id_last}; // RL18
                ADR_IRQ_STS: rdat_q <= {29'h0, irq_sts_q};
                ADR_IRQ_EN:  rdat_q <= {29'h0, irq_en_q};
                ADR_ACCESS:  rdat_q <= {15'h0, sec_q};
                default:     rdat_q <= '0;
            endcase
        end
    end

    // ************************************************
    // Spindle pin synchroniser
    // ************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            spd_sync_q <= 2'b00;
        end else begin
            spd_sync_q <= {spd_sync_q[0], spin_at_speed_i};
        end
    end
    assign at_speed = spd_sync_q[1];

    // ************************************************
    // Count decode
    // ************************************************
    isc_interval_dec u_dec (
        .count_i  (cnt),
        .secs_o   (dec_secs),
        .enable_o (dec_en),
        .abort_o  (dec_abort)
    );

    // ************************************************
    // Power state
    // ************************************************
    // Idle entry wins over expiry in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pwr_q <= PWR_ACTIVE;
        end else if ((is_idle && !dec_abort) || is_imm) begin
            pwr_q <= PWR_IDLE; // RL1 RL9
        end else if (expire) begin
            pwr_q <= PWR_STANDBY; // RL7
        end
    end

    // Spin-up held until the spindle reports speed or the timer expires
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            spin_req_q <= 1'b0;
        end else if ((is_idle && !dec_abort) || is_imm) begin
            spin_req_q <= !at_speed; // RL3 RL9
        end else if (at_speed || expire) begin
            spin_req_q <= 1'b0;
        end
    end

    // ************************************************
    // Stored standby period
    // ************************************************
    // Idle immediate never reaches this process
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            period_q <= '0;
            apd_en_q <= 1'b0;
        end else if (is_idle && !dec_abort) begin
            period_q <= dec_secs; // RL1 RL5 RL6 RL10
            apd_en_q <= dec_en;   // RL4
        end
    end

    // ************************************************
    // Prescaler; restarts on load so expiry is exact
    // ************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i || host_acc) begin
            pre_q <= '0;
        end else if (pre_q == 32'(TICK_LEN - 1)) begin
            pre_q <= '0; // RL19
        end else begin
            pre_q <= pre_q + 32'h1;
        end
    end
    assign tick = (pre_q == 32'(TICK_LEN - 1));

    // ************************************************
    // Standby countdown
    // ************************************************
    assign expire = apd_en_q && (pwr_q != PWR_STANDBY)
                 && tick && (sec_q == 17'h00001) && !host_acc;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sec_q <= '0;
        end else if (is_idle && !dec_abort) begin
            sec_q <= dec_secs; // RL1 RL2
        end else if (host_acc) begin
            sec_q <= period_q; // RL8
        end else if (tick && sec_q != '0 && pwr_q != PWR_STANDBY) begin
            sec_q <= sec_q - 17'h00001; // RL2
        end
    end

    // ************************************************
    // Status and error bytes
    // ************************************************
    // Fault and sense bits are never raised here
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ata_sts_q <= 8'h40;
            ata_err_q <= 8'h00;
        end else if (cmd_go) begin
            ata_sts_q                <= 8'h00;
            ata_sts_q[STS_RDY_BIT]   <= 1'b1;
            ata_sts_q[STS_ERR_BIT]   <= cmd_abort; // RL11
            ata_err_q                <= 8'h00;
            ata_err_q[ERR_ABORT_BIT] <= cmd_abort; // RL11
        end
    end

    // ************************************************
    // Geometry store
    // ************************************************
    // Zero sectors kept as zero, no wrap to 256
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            spt_q   <= SPT_RST;
            heads_q <= HEADS_RST;
        end else if (is_geom) begin
            spt_q   <= cnt;           // RL12 RL15
            heads_q <= wdat[19:16];   // RL12 RL16
        end else if (wr_stb && adr_i == ADR_SRST && feat_q == FEAT_REVERT) begin
            spt_q   <= SPT_RST;       // RL14
            heads_q <= HEADS_RST;
        end
    end

    // Soft-reset option byte
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            feat_q <= FEAT_KEEP;
        end else if (wr_stb && adr_i == ADR_FEAT) begin
            feat_q <= wdat[7:0];
        end
    end

    // ************************************************
    // Identify checksum
    // ************************************************
    isc_id_sum u_sum (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .clr_i   (wr_stb && adr_i == ADR_ID_LAST),
        .wr_i    (wr_stb && adr_i == ADR_ID_WR),
        .word_i  (wdat[15:0]),
        .spt_i   (spt_q),       // RL13
        .heads_i (heads_q),     // RL13
        .last_o  (id_last),
        .idx_o   (id_idx)
    );

    // ************************************************
    // Interrupts
    // ************************************************
    assign irq_set = {expire, cmd_abort, cmd_go && !cmd_abort};

    // Set wins over a clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_sts_q <= '0;
        end else if (wr_stb && adr_i == ADR_IRQ_CLR) begin
            irq_sts_q <= (irq_sts_q & ~wdat[IRQ_W-1:0]) | irq_set;
        end else begin
            irq_sts_q <= irq_sts_q | irq_set;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_en_q <= '0;
        end else if (wr_stb && adr_i == ADR_IRQ_EN) begin
            irq_en_q <= wdat[IRQ_W-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(irq_sts_q & irq_en_q);
        end
    end

    // ************************************************
    // Outputs
    // ************************************************
    assign ack_o         = ack_q;
    assign dat_o         = rdat_q;
    assign spin_up_req_o = spin_req_q;
    assign pwr_state_o   = pwr_q;
    assign irq_o         = irq_q;

    // ************************************************
    // Assertions
    // ************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_idle_enters: assert property ( // RL1
        is_idle && !dec_abort |=> pwr_q == PWR_IDLE && sec_q == $past(dec_secs))
        else $error("idle command did not enter idle with period");
    a_timer_counts: assert property ( // RL2
        tick && !host_acc && sec_q > 17'h1 && pwr_q != PWR_STANDBY
        |=> sec_q == $past(sec_q) - 17'h1)
        else $error("standby timer did not count down");
    a_spin_skip: assert property ( // RL3
        (is_idle || is_imm) && at_speed |=> !spin_up_req_o)
        else $error("spin-up requested while at speed");
    a_zero_off: assert property ( // RL4
        is_idle && cnt == CNT_OFF |=> !apd_en_q ##1 !expire)
        else $error("zero period left power-down enabled");
    a_linear_code: assert property ( // RL5
        is_idle && cnt != CNT_OFF && cnt <= CNT_LIN_MAX
        |=> period_q == SEC_PER_UNIT * 17'($past(cnt)))
        else $error("linear count decoded wrongly");
    a_abort_code: assert property ( // RL6
        is_idle && cnt == CNT_ABORT |=> ata_sts_q[STS_ERR_BIT]
        && ata_err_q[ERR_ABORT_BIT] && $stable(period_q))
        else $error("abort code not refused");
    a_expiry_sleep: assert property ( // RL7
        expire |=> pwr_state_o == PWR_STANDBY ##1 irq_sts_q[IRQ_SLEEP_BIT])
        else $error("expiry did not enter standby");
    a_access_reload: assert property ( // RL8
        host_acc && !cmd_go |=> sec_q == period_q)
        else $error("host access did not reload timer");
    a_imm_keeps: assert property ( // RL10
        is_imm |=> $stable(period_q) && $stable(apd_en_q) && pwr_q == PWR_IDLE)
        else $error("idle immediate changed stored period");
    a_geom_store: assert property ( // RL12
        is_geom |=> spt_q == $past(cnt) && heads_q == $past(wdat[19:16]))
        else $error("geometry not stored");
    a_ack_pulse: assert property (
        req |=> ack_o ##1 !ack_o)
        else $error("bus answer not a single pulse");

    c_idle_entry:  cover property (is_idle && !dec_abort && !at_speed);
    c_auto_sleep:  cover property (expire);
    c_abort:       cover property (cmd_abort);
    c_geom_revert: cover property (wr_stb && adr_i == ADR_SRST && feat_q == FEAT_REVERT);

endmodule // isc_cmd_unit

//--- isc_spindle_model.sv
// Behavioural spindle at the far side of the spin-up request pin.
// Assumes the request is held until the speed flag is seen.
`timescale 1ns/1ps
module isc_spindle_model (
    input  wire logic clk_i,         // System clock
    input  wire logic rst_i,         // Power-on reset, spindle stopped
    input  wire logic spin_up_req_i, // Spin-up request
    output logic      at_speed_o     // High once up to speed
);
    logic [3:0] ramp_q;  // Slow ramp, so the request is visible
    // Once at speed the spindle keeps turning
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ramp_q     <= 4'h0;
            at_speed_o <= 1'b0;
        end else if (spin_up_req_i) begin
            ramp_q     <= ramp_q + 4'h1;
            at_speed_o <= at_speed_o | (ramp_q == 4'hf);
        end
    end
endmodule // isc_spindle_model

//--- isc_cmd_unit_tb_top.sv
// Self-checking bench for the idle/standby command unit.
// Assumes a 10-cycle timer tick, so one second lasts 10 clocks.
`timescale 1ns/1ps
module isc_cmd_unit_tb_top;
    import isc_pkg::*;
    logic        clk, rst, we, cyc, stb, ack, irq, spd, req; // Bus and pins
    logic [7:0]  adr;              // Byte address
    logic [31:0] dat_w, dat_r, rd; // Write, read, captured data
    logic [1:0]  pwr;              // Power state
    int          n_errors, n_tests, c; // Counters
    // ************************************
    // Clock, design and spindle
    // ************************************
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    isc_cmd_unit #(.TICK_LEN(10)) i_dut (.clk_i(clk), .rst_i(rst), .adr_i(adr),
        .dat_i(dat_w), .dat_o(dat_r), .we_i(we), .sel_i(4'hf), .cyc_i(cyc),
        .stb_i(stb), .ack_o(ack), .spin_at_speed_i(spd), .spin_up_req_o(req),
        .pwr_state_o(pwr), .irq_o(irq));
    isc_spindle_model i_spin (.clk_i(clk), .rst_i(rst), .spin_up_req_i(req),
        .at_speed_o(spd));
    // ************************************
    // Shared tasks
    // ************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("FAIL %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    // Request held until ack is seen, then one idle cycle
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        {cyc, stb, we, adr, dat_w} <= {2'h3, w, a, d};
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        rd = dat_r;
        {cyc, stb, we} <= 3'h0;
        @(posedge clk);
    endtask
    // Bounded wait for a power state; c holds the cycles spent
    task automatic wait_st(input logic [1:0] s);
        c = 0;
        while (pwr !== s && c < 2000) begin
            @(posedge clk);
            c++;
        end
    endtask
    task automatic conclude();
        $display("Checks %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ************************************
    // Scenarios
    // ************************************
    task automatic t_idle();
        wb(ADR_STATUS, 1'b0, 32'h0);
        chk(rd, 32'h00000040);
        wb(8'h3c, 1'b0, 32'h0);
        chk(rd, 32'h0);
        wb(ADR_IRQ_EN, 1'b1, 32'h7);
        wb(ADR_CMD, 1'b1, 32'h000001e3);
        chk({30'h0, pwr}, 32'h1);
        chk({31'h0, req}, 32'h1);
        wait_st(2'h2);
        chk(32'(c >= 46 && c <= 52), 32'h1);
        wb(ADR_IRQ_STS, 1'b0, 32'h0);
        chk(rd, 32'h00000005);
        chk({31'h0, irq}, 32'h1);
        wb(ADR_IRQ_CLR, 1'b1, 32'h7);
        chk({31'h0, irq}, 32'h0);
        $display("t_idle done");
    endtask
    // Reload by access, then idle immediate keeps power-down enabled
    task automatic t_reload();
        wb(ADR_CMD, 1'b1, 32'h00000297);
        chk({29'h0, req, pwr}, 32'h1);
        repeat (60) @(posedge clk);
        wb(ADR_ACCESS, 1'b1, 32'h0);
        wb(ADR_ACCESS, 1'b0, 32'h0);
        chk(rd, 32'h0000000a);
        wait_st(2'h2);
        chk(32'(c >= 90 && c <= 98), 32'h1);
        wb(ADR_CMD, 1'b1, 32'h000000e1);
        chk({30'h0, pwr}, 32'h1);
        wb(ADR_STATUS, 1'b0, 32'h0);
        chk(rd, 32'h00090040);
        $display("t_reload done");
    endtask
    task automatic t_abort();
        wb(ADR_IRQ_CLR, 1'b1, 32'h7);
        wb(ADR_IRQ_EN, 1'b1, 32'h0);
        wb(ADR_CMD, 1'b1, 32'h0000fee3);
        wb(ADR_STATUS, 1'b0, 32'h0);
        chk(rd, 32'h00090441);
        chk({31'h0, irq}, 32'h0);
        wb(ADR_IRQ_EN, 1'b1, 32'h2);
        chk({31'h0, irq}, 32'h1);
        wb(ADR_CMD, 1'b1, 32'h0000f1e3);
        wb(ADR_ACCESS, 1'b0, 32'h0);
        chk(rd, 32'h00000708);
        wb(ADR_CMD, 1'b1, 32'h0000ffe3);
        wb(ADR_ACCESS, 1'b0, 32'h0);
        chk(rd, 32'h000004fb);
        wb(ADR_CMD, 1'b1, 32'h000000e3);
        wb(ADR_STATUS, 1'b0, 32'h0);
        chk(rd, 32'h00010040);
        repeat (200) @(posedge clk);
        chk({30'h0, pwr}, 32'h1);
        $display("t_abort done");
    endtask
    task automatic t_geom();
        wb(ADR_CMD, 1'b1, 32'h00073f91);
        wb(ADR_GEOM, 1'b0, 32'h0);
        chk(rd, 32'h0000073f);
        wb(ADR_CMD, 1'b1, 32'h00050091);
        wb(ADR_SRST, 1'b1, 32'h1);
        wb(ADR_GEOM, 1'b0, 32'h0);
        chk(rd, 32'h00000500);
        wb(ADR_FEAT, 1'b1, 32'h000000cc);
        wb(ADR_SRST, 1'b1, 32'h1);
        wb(ADR_GEOM, 1'b0, 32'h0);
        chk(rd, 32'h00000f3f);
        $display("t_geom done");
    endtask
    // Words 55 and 56 carry geometry 0x10/0x3f, so the sum ends at 0x59
    task automatic t_ident();
        wb(ADR_ID_LAST, 1'b1, 32'h0);
        for (int i = 0; i < 57; i++) begin
            wb(ADR_ID_WR, 1'b1, 32'h00001234);
        end
        wb(ADR_ID_WR, 1'b0, 32'h0);
        chk(rd, 32'h00000039);
        wb(ADR_ID_LAST, 1'b0, 32'h0);
        chk(rd, 32'h000002a5);
        $display("t_ident done");
    endtask
    // Main sequence and watchdog
    initial begin
        {rst, cyc, stb, we, adr, dat_w} = {4'h8, 8'h00, 32'h0};
        n_errors = 0;
        n_tests = 0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_idle();
        t_reload();
        t_abort();
        t_geom();
        t_ident();
        conclude();
    end
    initial begin
        repeat (5000) @(posedge clk);
        n_errors++;
        conclude();
    end
endmodule // isc_cmd_unit_tb_top
